// ===== logic/flash_self_program_control.sv
/*
 * self-programming control: control register, command arming,
 * busy tracking, address latch, core halt, lock/fuse readback.
 * assumes a core issuing store/load program requests as one-cycle
 * pulses and a flash array answering with a done pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flash_spm_consts.svh"
module flash_self_program_control #(
    parameter int PAGE_WORD_BITS = `PAGE_WORD_BITS,
    parameter logic [15:0] NO_READ_WHILE_WRITE_SECTION_START = `NO_READ_WHILE_WRITE_SECTION_START_WORD,
    parameter logic [15:0] BOOT_VECTOR = `BOOT_RESET_VEC
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire flash_spm_pkg::core_req_s i_core,
    input wire logic i_global_ie,
    input wire logic i_eeprom_busy,
    input wire logic i_boot_reset_fuse,
    input wire logic [7:0] i_lock_bits,
    input wire logic [7:0] i_fuse_bits,
    input wire logic i_flash_done,
    input wire logic [15:0] i_fetch_word_addr,
    output logic o_fetch_block,
    output logic [15:0] o_reset_vector,
    output logic o_ready_irq,
    output logic o_core_halt,
    output logic o_erase_start,
    output logic o_write_start,
    output logic o_lock_program,
    output logic [7:0] o_lock_value,
    output logic [15:0] o_flash_addr,
    output logic o_load_valid,
    output logic [7:0] o_load_data
);
    import flash_spm_pkg::*;

    localparam logic [1:0] REG_CTRL = 2'h0;

    // block state outside the window timer and page buffer in one record, so reset and update stay in one place
    typedef struct packed {
        // command sequencing
        spm_state_e state;
        // software visible control byte, bits 5 and 6 rebuilt each cycle
        logic [7:0] ctrl;
        // section blocked for reads until a re-enable or page load store clears it
        logic busy;
        // running operation targets the section the core executes from
        logic prog_no_read_while_write_section;
        // address frozen at operation start, pointer free afterwards
        logic [15:0] latched_addr;
        // read data, zero outside the cycle after a read strobe
        logic [7:0] rdata;
        // level request toward the interrupt controller
        logic irq;
        // core stall while the array cannot be fetched from
        logic halt;
        // one-cycle start pulses toward the array
        logic erase_start;
        logic write_start;
        logic lock_prog;
        // lock byte handed over with the lock pulse
        logic [7:0] lock_val;
        // one-cycle answer to a lock or fuse load
        logic load_valid;
        logic [7:0] load_data;
        // fetch address falls into the blocked section
        logic fetch_block;
        // vector picked once per reset so a moving fuse input cannot move it
        logic [15:0] reset_vector;
        logic vector_taken;
    } ctl_s;

    ctl_s cur;
    ctl_s next_cur;

    logic arm_write;
    logic store_open;
    logic load_open;
    logic window_stop;
    logic buf_clear;
    logic buf_write;
    logic buf_loaded;
    logic [4:0] cmd;

    initial begin
        if (PAGE_WORD_BITS < 1 || PAGE_WORD_BITS > 8) $error("bad page bits");
    end

    // a command is valid only in one of five shapes
    function automatic logic cmd_valid(input logic [4:0] c);
        case (c)
            `CMD_REENABLE, `CMD_LOCKSET, `CMD_PGWRITE, `CMD_PGERASE, `CMD_LOAD:
                cmd_valid = 1'b1;
            default:
                cmd_valid = 1'b0;
        endcase
    endfunction

    // true when a word address lies in the section that can be read while writing
    function automatic logic in_rww(input logic [15:0] word_addr);
        in_rww = word_addr < NO_READ_WHILE_WRITE_SECTION_START;
    endfunction

    assign cmd = i_wdata[4:0];
    // eeprom writes lock out arming entirely
    assign arm_write = i_wr && i_addr == REG_CTRL && cmd_valid(cmd) && !i_eeprom_busy
        && cur.state != st_prog;

    spm_window_timer #(
        .WIDTH(3)
    ) u_window (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_restart(arm_write),
        .i_stop(window_stop),
        .o_store_open(store_open),
        .o_load_open(load_open)
    );

    page_buffer #(
        .WORD_BITS(PAGE_WORD_BITS)
    ) u_buffer (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_clear(buf_clear),
        .i_write(buf_write),
        .i_addr(i_core.pointer[PAGE_WORD_BITS:1]),
        .i_data(i_core.r1r0),
        .i_rd_addr(cur.latched_addr[PAGE_WORD_BITS:1]),
        // buffer words go to the array side, not through this block
        .o_rd_data(),
        .o_any_loaded(buf_loaded)
    );

    // store and load strobes act only inside an open window
    logic store_hit;
    logic load_hit;
    logic [4:0] armed_cmd;
    assign armed_cmd = cur.ctrl[4:0];
    assign store_hit = cur.state == st_armed && store_open && i_core.store_req
        && !i_eeprom_busy;
    assign load_hit = cur.state == st_armed && load_open && i_core.load_req
        && armed_cmd == `CMD_LOCKSET && !i_eeprom_busy;
    assign buf_write = store_hit && armed_cmd == `CMD_LOAD;
    assign buf_clear = (store_hit && armed_cmd == `CMD_REENABLE)
        || (cur.state == st_prog && i_flash_done && cur.ctrl[`SPMC_BIT_PGWR])
        || (arm_write && cmd == `CMD_REENABLE && buf_loaded);
    assign window_stop = store_hit || load_hit;

    // main sequencing
    always_comb begin
        next_cur = cur;
        next_cur.erase_start = 1'b0;
        next_cur.write_start = 1'b0;
        next_cur.lock_prog = 1'b0;
        next_cur.load_valid = 1'b0;
        case (cur.state)
            st_idle, st_armed, st_done: begin
                if (arm_write) begin
                    // bits 7 kept, 6 and 5 not writable
                    next_cur.ctrl = {i_wdata[`SPMC_BIT_IE], 2'b00, cmd};
                    next_cur.state = st_armed;
                end else if (cur.state == st_armed && store_hit) begin
                    case (armed_cmd)
                        `CMD_PGERASE, `CMD_PGWRITE: begin
                            // freeze address so the pointer may move on
                            next_cur.latched_addr = {i_core.pointer[15:PAGE_WORD_BITS + 1],
                                {PAGE_WORD_BITS{1'b0}}, 1'b0};
                            next_cur.erase_start = armed_cmd == `CMD_PGERASE;
                            next_cur.write_start = armed_cmd == `CMD_PGWRITE;
                            if (in_rww(i_core.pointer >> 1)) begin
                                next_cur.busy = 1'b1;
                            end else begin
                                next_cur.prog_no_read_while_write_section = 1'b1;
                                next_cur.halt = 1'b1;
                            end
                            next_cur.state = st_prog;
                        end
                        `CMD_LOCKSET: begin
                            // pointer and R1 ignored, lock value from R0
                            next_cur.lock_prog = 1'b1;
                            next_cur.lock_val = i_core.r1r0[7:0];
                            next_cur.ctrl[4:0] = 5'h00;
                            next_cur.state = st_idle;
                        end
                        `CMD_REENABLE: begin
                            if (!cur.halt) begin
                                next_cur.busy = 1'b0;
                            end
                            next_cur.ctrl[4:0] = 5'h00;
                            next_cur.state = st_idle;
                        end
                        default: begin
                            next_cur.busy = 1'b0; // page load frees the section
                            next_cur.ctrl[4:0] = 5'h00;
                            next_cur.state = st_idle;
                        end
                    endcase
                end else if (cur.state == st_armed && load_hit) begin
                    // pointer bit 0 picks lock or fuse byte
                    next_cur.load_valid = 1'b1;
                    next_cur.load_data = i_core.pointer[0] ? i_lock_bits : i_fuse_bits;
                    next_cur.ctrl[4:0] = 5'h00;
                    next_cur.state = st_idle;
                end else if (cur.state == st_armed && !store_open) begin
                    next_cur.ctrl[4:0] = 5'h00; // timeout
                    next_cur.state = st_idle;
                end
            end
            st_prog: begin
                // store enable held until the array reports done
                if (i_flash_done) begin
                    next_cur.ctrl[4:0] = 5'h00;
                    next_cur.halt = 1'b0;
                    next_cur.prog_no_read_while_write_section = 1'b0;
                    next_cur.state = st_done;
                end
            end
            default: begin
                next_cur.state = st_idle;
            end
        endcase
        next_cur.ctrl[`SPMC_BIT_BUSY] = next_cur.busy;
        next_cur.ctrl[`SPMC_BIT_RSVD] = 1'b0;
        // level request, not a pulse
        next_cur.irq = next_cur.ctrl[`SPMC_BIT_IE] && i_global_ie
            && !next_cur.ctrl[`SPMC_BIT_EN];
        // fetch and load data from the busy section is not valid
        next_cur.fetch_block = next_cur.busy && in_rww(i_fetch_word_addr);
        next_cur.rdata = (i_rd && i_addr == REG_CTRL) ? cur.ctrl : 8'h00;
        // vector follows the fuse; no software path writes the fuse
        if (!cur.vector_taken) begin
            next_cur.reset_vector = i_boot_reset_fuse ? `APP_RESET_VEC : BOOT_VECTOR;
            next_cur.vector_taken = 1'b1;
        end
    end

    // single state register; vector captured after reset release
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            cur <= '0;
            cur.ctrl <= `SPMC_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // every output is a field of the state register, no logic after the flops
    assign o_rdata = cur.rdata;
    // level, stays up while software leaves the enable clear
    assign o_ready_irq = cur.irq;
    // held for the whole operation on the executing section
    assign o_core_halt = cur.halt;
    // start pulses, one cycle each
    assign o_erase_start = cur.erase_start;
    assign o_write_start = cur.write_start;
    assign o_lock_program = cur.lock_prog;
    assign o_lock_value = cur.lock_val;
    // byte address with page bits only; word bits come from the buffer side
    assign o_flash_addr = cur.latched_addr;
    // answer of a lock or fuse load, valid with its strobe only
    assign o_load_valid = cur.load_valid;
    assign o_load_data = cur.load_data;
    // one cycle behind the fetch address, the core must hold its fetch that long
    assign o_fetch_block = cur.fetch_block;
    // not valid until the first edge after reset release
    assign o_reset_vector = cur.reset_vector;
endmodule
`default_nettype wire

// ===== logic/flash_spm_consts.svh
/*
 * constants for the self-programming control block: register bits,
 * command patterns, window lengths, flash geometry defaults.
 * assumes inclusion by bare name from the package and design files.
 */
`ifndef FLASH_SPM_CONSTS_SVH
`define FLASH_SPM_CONSTS_SVH
`define SPMC_RESET 8'h00
`define SPMC_BIT_IE 7
`define SPMC_BIT_BUSY 6
`define SPMC_BIT_RSVD 5
`define SPMC_BIT_RE 4
`define SPMC_BIT_LOCK 3
`define SPMC_BIT_PGWR 2
`define SPMC_BIT_PGER 1
`define SPMC_BIT_EN 0
`define CMD_REENABLE 5'h11
`define CMD_LOCKSET 5'h09
`define CMD_PGWRITE 5'h05
`define CMD_PGERASE 5'h03
`define CMD_LOAD 5'h01
`define STORE_WINDOW 3'h4
`define LOAD_WINDOW 3'h3
`define APP_RESET_VEC 16'h0000
`define BOOT_RESET_VEC 16'h0c00
`define NO_READ_WHILE_WRITE_SECTION_START_WORD 16'h0c00
`define PAGE_WORD_BITS 5
`define BUF_WORDS 32
`define PROG_CYCLES 20'h1_0000
`endif

// ===== logic/flash_spm_pkg.sv
/*
 * types for the self-programming control block.
 * assumes the constants header sits beside it.
 */
`include "flash_spm_consts.svh"
package flash_spm_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_armed = 3'b001,
        st_prog = 3'b011,
        st_done = 3'b010
    } spm_state_e;

    // one core access toward the block
    typedef struct packed {
        logic store_req;
        logic load_req;
        logic [15:0] pointer;
        logic [15:0] r1r0;
    } core_req_s;
endpackage

// ===== logic/spm_window_timer.sv
/*
 * down counter for the arming windows; restart reloads it.
 * assumes single clock, synchronous active high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flash_spm_consts.svh"
module spm_window_timer #(
    parameter int WIDTH = 3
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_restart,
    input wire logic i_stop,
    output logic o_store_open,
    output logic o_load_open
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } tmr_s;
    tmr_s cur;
    tmr_s next_cur;

    initial begin
        if (WIDTH < 3) $error("window timer too narrow");
    end

    // reload on every arming write
    always_comb begin
        next_cur = cur;
        if (i_restart) begin
            next_cur.count = WIDTH'(`STORE_WINDOW);
        end else if (i_stop) begin
            next_cur.count = '0;
        end else if (cur.count != '0) begin
            next_cur.count = cur.count - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // load window is one cycle shorter than store window
    assign o_store_open = cur.count != '0;
    assign o_load_open = cur.count > WIDTH'(`STORE_WINDOW - `LOAD_WINDOW);
endmodule
`default_nettype wire

// ===== logic/page_buffer.sv
/*
 * temporary page buffer: word array with per-word valid bits.
 * assumes single clock; clear wipes all valid bits in one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module page_buffer #(
    parameter int WORD_BITS = 5
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clear,
    input wire logic i_write,
    input wire logic [WORD_BITS-1:0] i_addr,
    input wire logic [15:0] i_data,
    input wire logic [WORD_BITS-1:0] i_rd_addr,
    output logic [15:0] o_rd_data,
    output logic o_any_loaded
);
    localparam int DEPTH = 1 << WORD_BITS;
    logic [15:0] mem [DEPTH];
    logic [DEPTH-1:0] valid;

    initial begin
        if (WORD_BITS < 1 || WORD_BITS > 8) $error("bad page size");
    end

    // a discarded word reads as erased flash
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || i_clear) begin
            valid <= '0;
        end else if (i_write && !valid[i_addr]) begin
            valid[i_addr] <= 1'b1;
            mem[i_addr] <= i_data;
        end
    end

    assign o_rd_data = valid[i_rd_addr] ? mem[i_rd_addr] : 16'hffff;
    assign o_any_loaded = |valid;
endmodule
`default_nettype wire

// ===== bench/flash_spm_sva.sv
/* assertions on the self-programming control block, bound to its top.
   assumes one clock and a synchronous active high reset. */
`timescale 1ns/1ps
`default_nettype none
module flash_spm_sva #(
    parameter int PAGE_WORD_BITS = 5,
    parameter logic [15:0] BOOT_VECTOR = 16'h0c00
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire flash_spm_pkg::core_req_s i_core,
    input wire logic i_global_ie,
    input wire logic i_boot_reset_fuse,
    input wire logic [7:0] i_lock_bits,
    input wire logic [7:0] i_fuse_bits,
    input wire logic i_flash_done,
    input wire logic [15:0] o_reset_vector,
    input wire logic o_ready_irq,
    input wire logic o_core_halt,
    input wire logic o_erase_start,
    input wire logic o_write_start,
    input wire logic o_lock_program,
    input wire logic [7:0] o_lock_value,
    input wire logic [15:0] o_flash_addr,
    input wire logic o_load_valid,
    input wire logic [7:0] o_load_data
);
    import flash_spm_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    // every answer pulse follows its core request by one cycle
    sequence s_store_seen; $past(i_core.store_req); endsequence
    sequence s_load_seen; $past(i_core.load_req); endsequence
    // the vector settles on the first edge after reset; the check starts two edges after
    vector_select_a: assert property (!$past(i_reset) && !$past(i_reset, 2) |->
        o_reset_vector == (i_boot_reset_fuse ? 16'h0000 : BOOT_VECTOR))
        else $error("reset vector wrong");
    ready_irq_a: assert property (o_ready_irq |-> $past(i_global_ie) && !o_core_halt)
        else $error("ready request without its causes");
    halt_cause_a: assert property ($rose(o_core_halt) |->
        o_erase_start || o_write_start || $past(o_erase_start || o_write_start))
        else $error("halt without a started operation");
    halt_release_a: assert property (i_flash_done && o_core_halt |-> ##[1:2] !o_core_halt)
        else $error("halt outlived the operation");
    addr_stable_a: assert property (o_core_halt && $past(o_core_halt) |-> $stable(o_flash_addr))
        else $error("address moved during operation");
    page_addr_a: assert property (o_erase_start || o_write_start |-> s_store_seen ##0
        o_flash_addr == (($past(i_core.pointer) >> (PAGE_WORD_BITS + 1)) << (PAGE_WORD_BITS + 1)))
        else $error("page address not taken from pointer");
    lock_value_a: assert property (o_lock_program |-> s_store_seen ##0
        o_lock_value == $past(i_core.r1r0[7:0])) else $error("lock value not from low byte");
    load_data_a: assert property (o_load_valid |-> s_load_seen ##0
        o_load_data == ($past(i_core.pointer[0]) ? $past(i_lock_bits) : $past(i_fuse_bits)))
        else $error("load returned wrong bits");
endmodule
// parameters follow the bound instance so the page mask stays in step
bind flash_self_program_control flash_spm_sva #(
    .PAGE_WORD_BITS(PAGE_WORD_BITS), .BOOT_VECTOR(BOOT_VECTOR)
) u_flash_spm_sva (.*);
`default_nettype wire

// ===== bench/core_model.sv
/* processor core model: issues one store or load program request.
   assumes the bench raises i_go for one cycle per instruction. */
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_go,
    input wire logic i_is_load,
    input wire logic [15:0] i_ptr,
    input wire logic [15:0] i_word,
    output flash_spm_pkg::core_req_s o_core
);
    import flash_spm_pkg::*;
    // operands flip every cycle outside the request, so a late sampler sees junk
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_core <= '0;
        end else if (i_go) begin
            o_core <= '{store_req: !i_is_load, load_req: i_is_load, pointer: i_ptr, r1r0: i_word};
        end else begin
            o_core <= '{store_req: 1'b0, load_req: 1'b0, pointer: ~o_core.pointer,
                        r1r0: ~o_core.r1r0};
        end
    end
endmodule
`default_nettype wire

// ===== bench/tb_flash_self_program_control.sv
/* bench for the self-programming control block: register tasks and core model.
   assumes the checker is bound to the block and a 50 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_flash_self_program_control;
    import flash_spm_pkg::*;
    logic clk, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, gie = 1'b0, ee = 1'b0;
    logic fuse = 1'b1, done = 1'b0, go = 1'b0, ld_op = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, rdata, lockv, loadd, lv, ld;
    logic [15:0] fetch = 16'h0c10, ptr = 16'h0000, word = 16'h0000, vector, faddr, fa;
    logic fblk, irq, halt, ers, wrs, lockp, loadv;
    logic [3:0] seen;
    core_req_s core;
    int err_count, check_count, cycles;
    logic [7:0] bad [4] = '{8'h1f, 8'h07, 8'h80, 8'h02};
    logic [7:0] cmd [5] = '{8'h11, 8'h09, 8'h05, 8'h03, 8'h01};
    flash_self_program_control u_flash_self_program_control (
        .i_ref_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
        .i_rd(rd_s), .o_rdata(rdata), .i_core(core), .i_global_ie(gie), .i_eeprom_busy(ee),
        .i_boot_reset_fuse(fuse), .i_lock_bits(8'h3c), .i_fuse_bits(8'hd9),
        .i_flash_done(done), .i_fetch_word_addr(fetch), .o_fetch_block(fblk),
        .o_reset_vector(vector), .o_ready_irq(irq), .o_core_halt(halt), .o_erase_start(ers),
        .o_write_start(wrs), .o_lock_program(lockp), .o_lock_value(lockv),
        .o_flash_addr(faddr), .o_load_valid(loadv), .o_load_data(loadd));
    core_model u_core_model (.i_ref_clk(clk), .i_reset(rst), .i_go(go), .i_is_load(ld_op),
        .i_ptr(ptr), .i_word(word), .o_core(core));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            close_out();
        end
    end
    // four-state compare so an unknown never passes
    task chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= 2'h0;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task rchk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk("register", rdata, exp);
    endtask
    // delay counts extra cycles, so the slow core still has to fit the window
    task core_op(input logic l, input int dly, input logic [15:0] p, input logic [15:0] w);
        repeat (dly) @(posedge clk);
        go <= 1'b1;
        ld_op <= l;
        ptr <= p;
        word <= w;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task watch(input int n);
        seen = 4'h0;
        repeat (n) begin
            @(posedge clk);
            #1;
            seen = seen | {loadv, lockp, wrs, ers};
            if (ers || wrs) fa = faddr;
            if (lockp) lv = lockv;
            if (loadv) ld = loadd;
        end
    endtask
    task flash_done;
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task do_reset(input logic f);
        @(posedge clk);
        rst <= 1'b1;
        fuse <= f;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        do_reset(1'b1);
        chk("vector", vector, 16'h0000);
        rchk(2'h0, 8'h00);
        rchk(2'h2, 8'h00);
        foreach (bad[i]) begin
            wr(bad[i]);
            rchk(2'h0, 8'h00);
        end
        // each command arms with the reserved bit low, then times out
        foreach (cmd[i]) begin
            wr(cmd[i] | 8'ha0);
            rchk(2'h0, cmd[i] | 8'h80);
            repeat (4) @(posedge clk);
            rchk(2'h0, 8'h80);
        end
        chk("vector", vector, 16'h0000);
        gie <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("irq", irq, 1'b1);
        wr(8'h81);
        @(posedge clk);
        #1;
        chk("irq", irq, 1'b0);
        repeat (6) @(posedge clk);
        #1;
        chk("irq", irq, 1'b1);
        // re-arming restarts the window; slow store on the read section
        fetch <= 16'h0010;
        wr(8'h01);
        wr(8'h03);
        core_op(1'b0, 2, 16'h0047, 16'h1234);
        watch(3);
        chk("start", seen, 4'h1);
        chk("addr", fa, 16'h0040);
        chk("halt", halt, 1'b0);
        rchk(2'h0, 8'h43);
        chk("fetch", fblk, 1'b1);
        wr(8'h11);
        core_op(1'b0, 0, 16'h0000, 16'h0000);
        rchk(2'h0, 8'h43);
        flash_done();
        rchk(2'h0, 8'h40);
        wr(8'h11);
        core_op(1'b0, 0, 16'h0000, 16'h0000);
        rchk(2'h0, 8'h00);
        chk("fetch", fblk, 1'b0);
        // erase then write one page of the section the core runs from
        for (int k = 0; k < 2; k++) begin
            wr(k ? 8'h05 : 8'h03);
            core_op(1'b0, 0, 16'h1843, 16'h5555);
            watch(2);
            chk("start", seen, k ? 4'h2 : 4'h1);
            chk("addr", fa, 16'h1840);
            chk("halt", halt, 1'b1);
            flash_done();
            chk("halt", halt, 1'b0);
            rchk(2'h0, 8'h00);
        end
        wr(8'h09);
        core_op(1'b0, 1, 16'h0000, 16'hffc3);
        watch(3);
        chk("lockset", seen, 4'h4);
        chk("lockval", lv, 8'hc3);
        for (int k = 0; k < 2; k++) begin
            wr(8'h09);
            core_op(1'b1, 1, 16'(k), 16'h0000);
            watch(3);
            chk("load", seen, 4'h8);
            chk("loaddata", ld, k ? 8'h3c : 8'hd9);
        end
        // store one cycle past the window is dropped
        wr(8'h03);
        core_op(1'b0, 3, 16'h0040, 16'h0000);
        watch(3);
        chk("late", seen, 4'h0);
        ee <= 1'b1;
        wr(8'h03);
        rchk(2'h0, 8'h00);
        ee <= 1'b0;
        wr(8'h81);
        do_reset(1'b0);
        chk("vector", vector, 16'h0c00);
        rchk(2'h0, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
